// file: design/udbc_base.sv
// Shared constants of the up/down counter and its count-clock edge detector
`default_nettype none

package udbc_pkg;
	// Sizes
	localparam int CNT_W     = 4;
	localparam int APB_AW    = 8;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_LOAD   = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	// Control register fields
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam int CTRL_LD_BIT  = 2;
	// Status register fields
	localparam int ST_CNT_LSB  = 0;
	localparam int ST_TCU_BIT  = 8;
	localparam int ST_TCD_BIT  = 9;
	localparam int ST_UPL_BIT  = 10;
	localparam int ST_DNL_BIT  = 11;
	localparam int ST_WUP_BIT  = 16;
	localparam int ST_WDN_BIT  = 17;
	// Values after reset
	localparam logic        CTRL_EN_RST = 1'b1;
	localparam logic        TC_RST      = 1'b1;
	localparam logic        PREV_RST    = 1'b1;
	localparam logic        FLAG_RST    = 1'b0;
	localparam logic [31:0] WORD_RST    = 32'h0000_0000;
endpackage : udbc_pkg

// Rising-edge finder for one count clock sampled on pclk
module udbc_rise_detect
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic level_in,
	output logic      rise
);
	import udbc_pkg::*;

	logic prev_r;

	// Previous level; idle high so a clock held high at reset is no edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_r <= PREV_RST;
		else if (ce)
			prev_r <= level_in;
	end

	// Edge seen in the first cycle the level reads high
	assign rise = level_in & ~prev_r;

	a_rise_once : assert property (@(posedge pclk) disable iff (!presetn)
		ce && rise |=> !rise)
		else $error("rise flag stood two cycles");
endmodule : udbc_rise_detect

`default_nettype wire

// file: design/udbc_counter.sv
// Reversible four-bit counter with terminal-count outputs and APB registers
//
// Functional notes
// - Four-bit count wraps modulo sixteen, stepped by separate up and down clocks.
// - Up-clock rising edge adds one; down-clock rising edge subtracts one.
// - All count bits change together on the active clock edge.
// - Terminal outputs rest high; up one goes low at fifteen with up clock low.
// - Down terminal output follows a low down clock while count is zero.
// - Terminal outputs copy the clock waveform to drive a following stage.
// - Preset strobe low loads preset value at once, regardless of clocks.
// - Clear high overrides preset and clocks, forcing the count to zero.
// - A clock low through clear or preset counts its next rising edge.
// - Chained stages ripple, each lagging the one before by a small delay.
`default_nettype none

module udbc_counter
#(
	parameter int CNT_WIDTH = udbc_pkg::CNT_W,
	parameter int ADDR_W    = udbc_pkg::APB_AW
)
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ce,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 up_count_clock,
	input  wire logic                 down_count_clock,
	input  wire logic                 clear_input,
	input  wire logic                 preset_strobe_n,
	input  wire logic [CNT_WIDTH-1:0] preset_value,
	output logic      [CNT_WIDTH-1:0] count_value,
	output logic                      up_terminal_out_n,
	output logic                      down_terminal_out_n
);
	import udbc_pkg::*;

	localparam logic [CNT_WIDTH-1:0] CNT_MAX  = '1;
	localparam logic [CNT_WIDTH-1:0] CNT_ZERO = '0;
	localparam logic [CNT_WIDTH-1:0] CNT_ONE  = CNT_WIDTH'(1);

	// Status fields above bit 7 leave room for at most eight count bits
	if (CNT_WIDTH < 1 || CNT_WIDTH > 8)
	begin : g_bad_width
		$error("CNT_WIDTH must lie between 1 and 8");
	end
	if (ADDR_W < 4 || ADDR_W > 32)
	begin : g_bad_addr
		$error("ADDR_W must lie between 4 and 32");
	end

	logic [CNT_WIDTH-1:0] count_value_r;
	logic [CNT_WIDTH-1:0] count_nxt;
	logic [CNT_WIDTH-1:0] load_r;
	logic                 count_en_r;
	logic                 tcu_n_r;
	logic                 tcd_n_r;
	logic                 wrap_up_r;
	logic                 wrap_dn_r;
	logic [31:0]          prdata_r;
	logic [31:0]          rd_nxt;
	logic                 pready_r;
	logic                 pslverr_r;
	logic                 err_nxt;
	logic                 up_rise;
	logic                 dn_rise;
	logic                 wr_fire;
	logic                 wr_ctrl;
	logic                 wr_load;
	logic                 wr_status;
	logic                 clear_act;
	logic                 sw_load_act;
	logic                 hold_act;
	logic                 step_up;
	logic                 step_dn;
	logic [ADDR_W-1:0]    addr;

	// Count-clock edge finders
	udbc_rise_detect u_up_edge (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.level_in (up_count_clock),
		.rise     (up_rise)
	);

	udbc_rise_detect u_dn_edge (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.level_in (down_count_clock),
		.rise     (dn_rise)
	);

	// Bus decode; writes act at the completing edge only
	assign addr      = paddr;
	assign wr_fire   = psel & penable & pwrite & pready_r;
	assign wr_ctrl   = wr_fire && (addr == ADDR_W'(OFF_CTRL));
	assign wr_load   = wr_fire && (addr == ADDR_W'(OFF_LOAD));
	assign wr_status = wr_fire && (addr == ADDR_W'(OFF_STATUS));

	// Load and step conditions in priority order
	assign clear_act   = clear_input | (wr_ctrl & pwdata[CTRL_CLR_BIT]);
	assign sw_load_act = wr_ctrl & pwdata[CTRL_LD_BIT];
	assign hold_act    = clear_act | ~preset_strobe_n | sw_load_act;
	// Both edges together cancel; the driver should never do that
	assign step_up     = up_rise & ~dn_rise & count_en_r & ~hold_act;
	assign step_dn     = dn_rise & ~up_rise & count_en_r & ~hold_act;

	// Next count: clear beats preset beats software load beats a step
	always_comb
	begin
		count_nxt = count_value_r;
		if (clear_act)
			count_nxt = CNT_ZERO;
		else if (!preset_strobe_n)
			count_nxt = preset_value;
		else if (sw_load_act)
			count_nxt = load_r;
		else if (step_up)
			count_nxt = count_value_r + CNT_ONE;
		else if (step_dn)
			count_nxt = count_value_r - CNT_ONE;
	end

	// Whole word updates at one edge, never bit by bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_value_r <= CNT_ZERO;
		else if (ce)
			count_value_r <= count_nxt;
	end

	// Terminal outputs gate the live clock level, so they copy its waveform
	// one pclk behind; chained stages therefore ripple
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tcu_n_r <= TC_RST;
			tcd_n_r <= TC_RST;
		end
		else if (ce)
		begin
			tcu_n_r <= ~((count_nxt == CNT_MAX) & ~up_count_clock);
			tcd_n_r <= ~((count_nxt == CNT_ZERO) & ~down_count_clock);
		end
	end

	// Software control: count enable and software load value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_en_r <= CTRL_EN_RST;
			load_r     <= CNT_ZERO;
		end
		else if (ce)
		begin
			if (wr_ctrl)
				count_en_r <= pwdata[CTRL_EN_BIT];
			if (wr_load)
				load_r <= pwdata[CNT_WIDTH-1:0];
		end
	end

	// Sticky wrap flags; a wrap in the clearing cycle wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wrap_up_r <= FLAG_RST;
			wrap_dn_r <= FLAG_RST;
		end
		else if (ce)
		begin
			if (step_up && count_value_r == CNT_MAX)
				wrap_up_r <= 1'b1;
			else if (wr_status && pwdata[ST_WUP_BIT])
				wrap_up_r <= 1'b0;
			if (step_dn && count_value_r == CNT_ZERO)
				wrap_dn_r <= 1'b1;
			else if (wr_status && pwdata[ST_WDN_BIT])
				wrap_dn_r <= 1'b0;
		end
	end

	// Read data and error for the addressed word
	always_comb
	begin
		rd_nxt  = WORD_RST;
		err_nxt = 1'b0;
		if (addr == ADDR_W'(OFF_CTRL))
			rd_nxt[CTRL_EN_BIT] = count_en_r;
		else if (addr == ADDR_W'(OFF_LOAD))
			rd_nxt[CNT_WIDTH-1:0] = load_r;
		else if (addr == ADDR_W'(OFF_STATUS))
		begin
			rd_nxt[ST_CNT_LSB +: CNT_WIDTH] = count_value_r;
			rd_nxt[ST_TCU_BIT] = tcu_n_r;
			rd_nxt[ST_TCD_BIT] = tcd_n_r;
			rd_nxt[ST_UPL_BIT] = up_count_clock;
			rd_nxt[ST_DNL_BIT] = down_count_clock;
			rd_nxt[ST_WUP_BIT] = wrap_up_r;
			rd_nxt[ST_WDN_BIT] = wrap_dn_r;
		end
		else
			err_nxt = 1'b1;
	end

	// One wait state keeps every bus output on a flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= WORD_RST;
		end
		else if (ce)
		begin
			if (psel && penable && !pready_r)
			begin
				pready_r  <= 1'b1;
				pslverr_r <= err_nxt;
				prdata_r  <= pwrite ? WORD_RST : rd_nxt;
			end
			else
			begin
				pready_r  <= 1'b0;
				pslverr_r <= 1'b0;
				prdata_r  <= WORD_RST;
			end
		end
	end

	// Outputs
	assign prdata              = prdata_r;
	assign pready              = pready_r;
	assign pslverr             = pslverr_r;
	assign count_value         = count_value_r;
	assign up_terminal_out_n   = tcu_n_r;
	assign down_terminal_out_n = tcd_n_r;

	// Checks on the counting path
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_up_step_adds : assert property (
		ce && step_up && count_value_r != CNT_MAX
		|=> count_value_r == $past(count_value_r) + CNT_ONE)
		else $error("up edge did not add one");

	a_down_step_subs : assert property (
		ce && step_dn && count_value_r != CNT_ZERO
		|=> count_value_r == $past(count_value_r) - CNT_ONE)
		else $error("down edge did not subtract one");

	a_wrap_both_ways : assert property (
		ce && ((step_up && count_value_r == CNT_MAX)
		|| (step_dn && count_value_r == CNT_ZERO))
		|=> count_value_r == ($past(step_up) ? CNT_ZERO : CNT_MAX))
		else $error("count did not wrap at its limit");

	a_single_step_only : assert property (
		ce && !hold_act ##1 !$stable(count_value_r)
		|-> count_value_r == $past(count_value_r) + CNT_ONE
		|| count_value_r == $past(count_value_r) - CNT_ONE)
		else $error("count moved by more than one");

	a_clear_wins_all : assert property (
		ce && clear_input |=> count_value_r == CNT_ZERO && !$rose(wrap_up_r))
		else $error("clear did not force zero");

	a_preset_loads_now : assert property (
		ce && !clear_act && !preset_strobe_n
		|=> count_value_r == $past(preset_value))
		else $error("preset value not taken");

	a_tcu_low_at_max : assert property (
		ce && count_nxt == CNT_MAX && !up_count_clock
		|=> !up_terminal_out_n ##0 count_value_r == CNT_MAX)
		else $error("up terminal not low at fifteen");

	a_tc_rest_high : assert property (
		ce && up_count_clock && down_count_clock
		|=> up_terminal_out_n && down_terminal_out_n)
		else $error("terminal output low with clock high");

	a_tcd_follows_clk : assert property (
		ce && count_nxt == CNT_ZERO
		|=> down_terminal_out_n == $past(down_count_clock))
		else $error("down terminal does not follow clock at zero");

	a_edge_after_clear : assert property (
		ce && clear_input && !up_count_clock && count_en_r
		##1 ce && !hold_act && up_count_clock && !dn_rise && count_en_r
		|=> count_value_r == CNT_ONE)
		else $error("first edge after clear was lost");

	a_apb_one_wait : assert property (
		ce && psel && penable && !pready_r |=> pready_r ##1 (!pready_r || !$past(ce)))
		else $error("bus answer not after one wait state");

	a_tcu_follows_clk : assert property (
		ce && count_nxt == CNT_MAX
		|=> up_terminal_out_n == $past(up_count_clock))
		else $error("up terminal does not follow clock at fifteen");

	a_tcd_low_at_zero : assert property (
		ce && count_nxt == CNT_ZERO && !down_count_clock
		|=> !down_terminal_out_n ##0 count_value_r == CNT_ZERO)
		else $error("down terminal not low at zero");

	// Hold checks; a frozen enable must stop every register
	a_disabled_holds : assert property (
		ce && !count_en_r && !hold_act |=> $stable(count_value_r))
		else $error("count moved while counting was off");

	a_freeze_holds : assert property (
		!ce |=> $stable(count_value_r) && $stable(tcu_n_r) && $stable(tcd_n_r)
		&& $stable(pready_r) && $stable(wrap_up_r) && $stable(wrap_dn_r))
		else $error("state moved while clock enable was low");

	a_bus_err_mapped : assert property (
		ce && psel && penable && !pready_r && !err_nxt |=> !pslverr_r)
		else $error("error flagged on a mapped word");

	c_wrap_up   : cover property (ce && step_up && count_value_r == CNT_MAX);
	c_wrap_down : cover property (ce && step_dn && count_value_r == CNT_ZERO);
	c_preset    : cover property (ce && !preset_strobe_n ##1 ce && step_up);
	c_tcu_pulse : cover property (!up_terminal_out_n ##1 up_terminal_out_n);
	c_freeze    : cover property (!ce ##1 ce);
endmodule : udbc_counter

`default_nettype wire

// file: verification/udbc_clk_driver.sv
// Count-clock driver standing in for the control logic ahead of the counter
`default_nettype none

module udbc_clk_driver
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go_up,
	input  wire logic       go_dn,
	input  wire logic [3:0] low_len,
	output logic            up_count_clock,
	output logic            down_count_clock,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left_r;

	// Each set go input lowers its own clock; both rest high, so direction changes while high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			up_count_clock   <= 1'b1;
			down_count_clock <= 1'b1;
			left_r           <= 4'h0;
			busy             <= 1'b0;
		end
		else if (go_up || go_dn)
		begin
			up_count_clock   <= !go_up;
			down_count_clock <= !go_dn;
			left_r           <= low_len;
			busy             <= 1'b1;
		end
		else if (left_r > 4'h1)
			left_r <= left_r - 4'h1;
		else
		begin
			up_count_clock   <= 1'b1;
			down_count_clock <= 1'b1;
			left_r           <= 4'h0;
			busy             <= 1'b0;
		end
	end
endmodule : udbc_clk_driver

`default_nettype wire

// file: verification/test_up_down_binary_counter.sv
// Self-checking bench: APB registers, count clocks, preset and clear
`default_nettype none

module test_up_down_binary_counter
	import udbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, busy, up_count_clock, down_count_clock;
	logic        up_terminal_out_n, down_terminal_out_n;
	logic        clear_input = 1'b0, preset_strobe_n = 1'b1, go_up = 1'b0, go_dn = 1'b0;
	logic        ce = 1'b1;
	logic [3:0]  preset_value = 4'h0, low_len = 4'h1, count_value;
	int          fail_count = 0, total_checks = 0, cyc = 0;

	udbc_counter dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .up_count_clock, .down_count_clock,
		.clear_input, .preset_strobe_n, .preset_value, .count_value, .up_terminal_out_n,
		.down_terminal_out_n);
	udbc_clk_driver drv_u (.pclk, .presetn, .go_up, .go_dn, .low_len, .up_count_clock,
		.down_count_clock, .busy);

	always #5 pclk = ~pclk;

	// Cut a hang short; the whole run needs well under a thousand cycles
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; an idle cycle after it keeps strobes from double assignment
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Lower one count clock for len cycles; returns while it is still low if len exceeds 2
	task automatic start(input logic up, input logic [3:0] len);
		go_up <= up;
		go_dn <= !up;
		low_len <= len;
		@(posedge pclk);
		go_up <= 1'b0;
		go_dn <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : start

	task automatic finish();
		while (busy === 1'b1) @(posedge pclk);
		repeat (2) @(posedge pclk);
	endtask : finish

	task automatic step(input logic up, input int n);
		repeat (n)
		begin
			start(up, 4'h1);
			finish();
		end
	endtask : step

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({28'h0, count_value}, 32'h0);
		chk({30'h0, up_terminal_out_n, down_terminal_out_n}, 32'h3);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h1);
		chk({31'h0, err}, 32'h0);
		apb(1'b0, OFF_LOAD, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		step(1'b1, 15);
		chk({28'h0, count_value}, 32'hf);
		chk({31'h0, up_terminal_out_n}, 32'h1);
		start(1'b1, 4'h4);
		chk({30'h0, up_terminal_out_n, down_terminal_out_n}, 32'h1);
		finish();
		chk({27'h0, count_value, up_terminal_out_n}, 32'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h0003_0fff, 32'h0001_0f00);
		apb(1'b1, OFF_STATUS, 32'h0001_0000);
		start(1'b0, 4'h4);
		chk({30'h0, up_terminal_out_n, down_terminal_out_n}, 32'h2);
		finish();
		chk({28'h0, count_value}, 32'hf);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h0003_0fff, 32'h0002_0f0f);
		step(1'b0, 1);
		chk({28'h0, count_value}, 32'he);
		// Clear and preset together: clear must win
		preset_value <= 4'ha;
		preset_strobe_n <= 1'b0;
		clear_input <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({28'h0, count_value}, 32'h0);
		clear_input <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({28'h0, count_value}, 32'ha);
		preset_strobe_n <= 1'b1;
		// Clock held low across a clear still counts its rise
		start(1'b1, 4'h8);
		clear_input <= 1'b1;
		repeat (2) @(posedge pclk);
		clear_input <= 1'b0;
		finish();
		chk({28'h0, count_value}, 32'h1);
		// Same, with the rise in the cycle right after the clear
		start(1'b1, 4'h4);
		clear_input <= 1'b1;
		repeat (2) @(posedge pclk);
		clear_input <= 1'b0;
		finish();
		chk({28'h0, count_value}, 32'h1);
		apb(1'b1, OFF_LOAD, 32'h5);
		apb(1'b0, OFF_LOAD, 32'h0);
		chk(rd, 32'h5);
		apb(1'b1, OFF_CTRL, 32'h5);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h1);
		chk({28'h0, count_value}, 32'h5);
		apb(1'b1, OFF_CTRL, 32'h0);
		step(1'b1, 2);
		chk({28'h0, count_value}, 32'h5);
		apb(1'b1, OFF_CTRL, 32'h1);
		step(1'b1, 1);
		chk({28'h0, count_value}, 32'h6);
		apb(1'b1, OFF_CTRL, 32'h3);
		repeat (2) @(posedge pclk);
		chk({28'h0, count_value}, 32'h0);
		// Frozen clock enable: a preset in that time is not taken
		preset_value <= 4'h3;
		preset_strobe_n <= 1'b0;
		ce <= 1'b0;
		repeat (2) @(posedge pclk);
		preset_strobe_n <= 1'b1;
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({28'h0, count_value}, 32'h0);
		test_done();
	end
endmodule : test_up_down_binary_counter

`default_nettype wire
